// File: logic/bpu_top.v
// Purpose: Branch target cache, history, fallback predictor and return stack
// Assumes: Pipeline resolves branches and drives update, push and flush strobes
// Notes:   Outputs are registered; lookup answer comes two cycles after request
//
// Behaviour
// - 128-entry direct mapped virtual target cache
// - Two-bit saturating history per entry
// - Entry replaced only by different branch, same index
// - History updated on every resolved execution while enable bit is one, outside flush
// - Allocate after resolve, taken or not taken
// - Taken hit gives target as next fetch
// - Two-cycle pipelined lookup, one per cycle
// - Flush operation clears whole target cache
// - Offset sign: backward taken, forward not taken
// - Fallback acts only on dynamic misses
// - Fallback taken adds one cycle delay
// - Fallback off in bytecode state
// - Predict only while enable bit is one
// - Fold dynamic branches except listed exceptions
// - Resolve by third stage, mispredict flushes fetch
// - Failed folded branch fails following instruction
// - Store recovery address for uncertain predictions
// - Forward condition field, restart at recovery
// - Three-entry circular return stack, unconditional returns
// - Push execute-stage return address on calls
// - Fallback: unconditional calls taken, conditional not
// - Return predicts top of stack, pops; empty none
// - Enable bit 11, cleared on reset
`timescale 1ns/1ps
`include "bpu_regs.vh"

module bpu_top #(
	parameter AW      = 32,
	parameter IDX_W   = 7,
	parameter ENTRIES = 128,
	parameter RS_N    = 3
) (
	input  wire          clk,
	input  wire          rst,
	// System control register write
	input  wire          ctrl_wr,
	input  wire [31:0]   ctrl_wdata,
	input  wire          flush_pred,
	input  wire [1:0]    exec_state,
	// Lookup from fetch
	input  wire          lk_valid,
	input  wire [AW-1:0] lk_addr,
	input  wire          lk_link,
	input  wire          lk_onto_pred,
	input  wire          lk_bkpt_abort,
	input  wire [3:0]    lk_cond,
	// Decode-stage static candidate
	input  wire          sb_valid,
	input  wire          sb_dyn_hit,
	input  wire          sb_cond,
	input  wire          sb_call,
	input  wire          sb_ret,
	input  wire [AW-1:0] sb_pc,
	input  wire [AW-1:0] sb_next_pc,
	input  wire [AW-1:0] sb_offset,
	// Resolution from execute
	input  wire          rs_valid,
	input  wire [AW-1:0] rs_pc,
	input  wire [AW-1:0] rs_target,
	input  wire          rs_taken,
	input  wire          rs_call,
	input  wire [AW-1:0] rs_ret_addr,
	input  wire          rs_mispredict,
	input  wire          rs_fold_fail,
	// Outputs
	output reg           pred_en_reg,
	output reg           lk_hit_reg,
	output reg           lk_taken_reg,
	output reg  [AW-1:0] lk_target_reg,
	output reg           lk_fold_reg,
	output reg  [3:0]    lk_cond_reg,
	output reg  [AW-1:0] lk_recover_reg,
	output reg           sb_redirect_reg,
	output reg  [AW-1:0] sb_target_reg,
	output reg  [AW-1:0] sb_recover_reg,
	output reg           flush_fetch_reg,
	output reg  [AW-1:0] restart_pc_reg,
	output reg           kill_next_reg
);

	localparam TAG_W = AW - IDX_W - 2;

	// ----------------------------------------
	// Target cache storage
	// ----------------------------------------
	reg             ent_valid [0:ENTRIES-1];
	reg [TAG_W-1:0] ent_tag   [0:ENTRIES-1];
	reg [AW-1:0]    ent_tgt   [0:ENTRIES-1];
	reg [1:0]       ent_hist  [0:ENTRIES-1];

	wire [IDX_W-1:0] lk_idx = lk_addr[IDX_W+1:2];
	wire [TAG_W-1:0] lk_tag = lk_addr[AW-1:IDX_W+2];
	wire [IDX_W-1:0] up_idx = rs_pc[IDX_W+1:2];
	wire [TAG_W-1:0] up_tag = rs_pc[AW-1:IDX_W+2];

	// ----------------------------------------
	// Control enable
	// ----------------------------------------
	always @(posedge clk or posedge rst) begin
		if (rst)
			pred_en_reg <= `BPU_CTRL_EN_RST;
		else if (ctrl_wr)
			pred_en_reg <= ctrl_wdata[`BPU_CTRL_EN_BIT];
	end

	// ----------------------------------------
	// Update and allocate
	// ----------------------------------------
	wire       up_match = ent_valid[up_idx] && (ent_tag[up_idx] == up_tag);
	reg  [1:0] hist_next;

	always @* begin
		hist_next = ent_hist[up_idx];
		if (!up_match)
			hist_next = rs_taken ? `BPU_HIST_ALLOC_T : `BPU_HIST_ALLOC_N;
		else if (rs_taken && ent_hist[up_idx] != `BPU_HIST_ST)
			hist_next = ent_hist[up_idx] + 2'b01;
		else if (!rs_taken && ent_hist[up_idx] != `BPU_HIST_SN)
			hist_next = ent_hist[up_idx] - 2'b01;
	end

	integer i;
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			for (i = 0; i < ENTRIES; i = i + 1)
				ent_valid[i] <= 1'b0;
		end else if (flush_pred) begin
			for (i = 0; i < ENTRIES; i = i + 1)
				ent_valid[i] <= 1'b0;
		end else if (rs_valid && pred_en_reg) begin
			ent_valid[up_idx] <= 1'b1;
		end
	end

	always @(posedge clk) begin
		if (rs_valid && pred_en_reg && !flush_pred) begin
			ent_hist[up_idx] <= hist_next;
			if (!up_match) begin
				ent_tag[up_idx] <= up_tag;
				ent_tgt[up_idx] <= rs_target;
			end
		end
	end

	// ----------------------------------------
	// Two-stage lookup pipeline
	// ----------------------------------------
	reg              s1_valid;
	reg [IDX_W-1:0]  s1_idx;
	reg [TAG_W-1:0]  s1_tag;
	reg [AW-1:0]     s1_fall;
	reg              s1_nofold;
	reg [3:0]        s1_cond;

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_valid  <= 1'b0;
			s1_idx    <= {IDX_W{1'b0}};
			s1_tag    <= {TAG_W{1'b0}};
			s1_fall   <= {AW{1'b0}};
			s1_nofold <= 1'b0;
			s1_cond   <= 4'h0;
		end else begin
			s1_valid  <= lk_valid && pred_en_reg;
			s1_idx    <= lk_idx;
			s1_tag    <= lk_tag;
			s1_fall   <= lk_addr + 32'h0000_0004;
			s1_nofold <= lk_link | lk_onto_pred | lk_bkpt_abort;
			s1_cond   <= lk_cond;
		end
	end

	wire s1_hit   = s1_valid && ent_valid[s1_idx] && (ent_tag[s1_idx] == s1_tag);
	wire s1_taken = s1_hit && ent_hist[s1_idx][1];

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			lk_hit_reg     <= 1'b0;
			lk_taken_reg   <= 1'b0;
			lk_target_reg  <= {AW{1'b0}};
			lk_fold_reg    <= 1'b0;
			lk_cond_reg    <= 4'h0;
			lk_recover_reg <= {AW{1'b0}};
		end else begin
			lk_hit_reg     <= s1_hit && !flush_pred;
			lk_taken_reg   <= s1_taken && !flush_pred;
			lk_target_reg  <= ent_tgt[s1_idx];
			lk_fold_reg    <= s1_hit && !s1_nofold && !flush_pred;
			lk_cond_reg    <= s1_cond;
			lk_recover_reg <= s1_taken ? s1_fall : ent_tgt[s1_idx];
		end
	end

	// ----------------------------------------
	// Return address stack
	// ----------------------------------------
	reg [AW-1:0] ras_mem [0:RS_N-1];
	reg [1:0]    ras_top_reg;
	reg [1:0]    ras_cnt_reg;

	wire [1:0] ras_up  = (ras_top_reg == RS_N - 1) ? 2'd0 : ras_top_reg + 2'd1;
	localparam [1:0] RAS_LAST = RS_N - 1;
	wire [1:0] ras_dn  = (ras_top_reg == 2'd0) ? RAS_LAST : ras_top_reg - 2'd1;
	wire       ras_pop = sb_valid && pred_en_reg && sb_ret && !sb_cond
	                     && (ras_cnt_reg != 2'd0);
	wire       ras_push = rs_valid && pred_en_reg && rs_call;

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			ras_top_reg <= 2'd0;
			ras_cnt_reg <= 2'd0;
		end else if (flush_pred) begin
			ras_cnt_reg <= 2'd0;
		end else if (ras_push) begin
			ras_top_reg <= ras_up;
			if (ras_cnt_reg != RS_N)
				ras_cnt_reg <= ras_cnt_reg + 2'd1;
		end else if (ras_pop) begin
			ras_top_reg <= ras_dn;
			ras_cnt_reg <= ras_cnt_reg - 2'd1;
		end
	end

	always @(posedge clk) begin
		if (ras_push && !flush_pred)
			ras_mem[ras_up] <= rs_ret_addr;
	end

	// ----------------------------------------
	// Direction fallback predictor
	// ----------------------------------------
	wire sb_act  = sb_valid && pred_en_reg && !sb_dyn_hit
	               && exec_state != `BPU_ST_BYTECODE;
	wire sb_dir  = sb_call ? !sb_cond : (sb_offset[AW-1] | !sb_cond);
	wire sb_tk   = sb_act && !sb_ret && sb_dir;
	wire [AW-1:0] sb_tgt = sb_pc + sb_offset;

	reg          sd_pend;
	reg [AW-1:0] sd_tgt;
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			sd_pend         <= 1'b0;
			sd_tgt          <= {AW{1'b0}};
			sb_redirect_reg <= 1'b0;
			sb_target_reg   <= {AW{1'b0}};
			sb_recover_reg  <= {AW{1'b0}};
		end else begin
			sd_pend         <= sb_tk;
			sd_tgt          <= sb_tgt;
			sb_redirect_reg <= (sd_pend && !flush_pred) || ras_pop;
			sb_target_reg   <= ras_pop ? ras_mem[ras_top_reg] : sd_tgt;
			if (sb_act)
				sb_recover_reg <= sb_tk ? sb_next_pc : sb_tgt;
		end
	end

	// ----------------------------------------
	// Misprediction recovery
	// ----------------------------------------
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			flush_fetch_reg <= 1'b0;
			restart_pc_reg  <= {AW{1'b0}};
			kill_next_reg   <= 1'b0;
		end else begin
			flush_fetch_reg <= rs_valid && rs_mispredict;
			restart_pc_reg  <= rs_taken ? rs_target : rs_ret_addr;
			kill_next_reg   <= rs_valid && rs_fold_fail;
		end
	end

endmodule // bpu_top

// File: logic/bpu_regs.vh
// Purpose: Constants for the branch prediction unit
// Assumes: 32-bit virtual addresses, word aligned native instructions
// Notes:   Included by bpu_top.v
`ifndef BPU_REGS_VH
`define BPU_REGS_VH

// Control register enable bit position and reset value
`define BPU_CTRL_EN_BIT     11
`define BPU_CTRL_EN_RST     1'b0
// History counter encodings
`define BPU_HIST_ST         2'b11
`define BPU_HIST_WT         2'b10
`define BPU_HIST_WN         2'b01
`define BPU_HIST_SN         2'b00
`define BPU_HIST_ALLOC_T    2'b10
`define BPU_HIST_ALLOC_N    2'b01
// Lookup latency in cycles
`define BPU_LOOKUP_LAT      2
// Static taken delay in cycles
`define BPU_STATIC_DELAY    1
// Execution states
`define BPU_ST_NATIVE       2'b00
`define BPU_ST_COMPACT      2'b01
`define BPU_ST_BYTECODE     2'b10

`endif

// File: bench/bpu_top_properties.sv
// Purpose: Port properties of the branch prediction unit
// Assumes: Registered outputs with the handed-over latencies
// Notes:   Bound to bpu_top
`timescale 1ns/1ps
module bpu_top_props #(
	parameter AW = 32
) (
	input wire          clk,
	input wire          rst,
	input wire          ctrl_wr,
	input wire [31:0]   ctrl_wdata,
	input wire          lk_valid,
	input wire [AW-1:0] lk_addr,
	input wire          rs_valid,
	input wire          rs_taken,
	input wire [AW-1:0] rs_target,
	input wire [AW-1:0] rs_ret_addr,
	input wire          rs_mispredict,
	input wire          rs_fold_fail,
	input wire          pred_en_reg,
	input wire          lk_hit_reg,
	input wire          lk_taken_reg,
	input wire [AW-1:0] lk_recover_reg,
	input wire          sb_redirect_reg,
	input wire          flush_fetch_reg,
	input wire [AW-1:0] restart_pc_reg,
	input wire          kill_next_reg
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_enable_set: assert property (ctrl_wr && ctrl_wdata[11] |=> pred_en_reg)
		else $error("enable not set by write");
	a_enable_hold: assert property (!ctrl_wr |=> $stable(pred_en_reg))
		else $error("enable changed without write");
	a_hit_cause: assert property (lk_hit_reg |-> $past(lk_valid, 2) && $past(pred_en_reg, 2))
		else $error("hit without enabled lookup");
	a_taken_recovery: assert property (lk_hit_reg && lk_taken_reg |->
		lk_recover_reg == $past(lk_addr, 2) + 32'h0000_0004) else $error("bad recovery");
	a_off_quiet: assert property (!pred_en_reg && !$past(pred_en_reg) &&
		!$past(pred_en_reg, 2) |-> !lk_hit_reg && !sb_redirect_reg) else $error("predicted off");
	a_restart_pc: assert property (rs_valid && rs_mispredict && pred_en_reg |=>
		flush_fetch_reg && restart_pc_reg == ($past(rs_taken) ? $past(rs_target) :
		$past(rs_ret_addr))) else $error("bad restart");
	a_flush_cause: assert property (flush_fetch_reg |-> $past(rs_valid) && $past(rs_mispredict))
		else $error("flush without mispredict");
	a_fold_kill: assert property (rs_valid && rs_fold_fail && pred_en_reg |=> kill_next_reg)
		else $error("no kill after fold fail");
	c_taken_hit: cover property (lk_hit_reg && lk_taken_reg);
	c_redirect: cover property (sb_redirect_reg);
	c_restart: cover property (flush_fetch_reg);
endmodule // bpu_top_props

bind bpu_top bpu_top_props #(.AW(AW)) u_props (.*);

// File: bench/bpu_pipe_model.sv
// Purpose: Integer pipeline stand-in issuing branch resolutions
// Assumes: Signals change 1 ns after the rising edge
// Notes:   Released data lines show the inverse of the last value
`timescale 1ns/1ps
module bpu_pipe_model (
	input  wire         clk,
	output logic        rs_valid,
	output logic        rs_taken,
	output logic        rs_call,
	output logic        rs_mispredict,
	output logic        rs_fold_fail,
	output logic [31:0] rs_pc,
	output logic [31:0] rs_target,
	output logic [31:0] rs_ret_addr
);
	initial {rs_valid, rs_call, rs_mispredict, rs_fold_fail, rs_taken, rs_pc, rs_target,
		rs_ret_addr} = '0;
	task automatic resolve(input logic [31:0] pc, tg, ra, input logic tk, cl, mp, ff);
		@(posedge clk);
		#1;
		{rs_pc, rs_target, rs_ret_addr, rs_taken} = {pc, tg, ra, tk};
		{rs_valid, rs_call, rs_mispredict, rs_fold_fail} = {1'b1, cl, mp, ff};
		@(posedge clk);
		#1;
		{rs_pc, rs_target, rs_ret_addr, rs_taken} = ~{pc, tg, ra, tk};
		{rs_valid, rs_call, rs_mispredict, rs_fold_fail} = 4'h0;
	endtask
endmodule // bpu_pipe_model

// File: bench/branch_prediction_unit_bench.sv
// Purpose: Self-checking bench for the branch prediction unit
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Resolutions come from the pipeline model
`timescale 1ns/1ps
`include "bpu_regs.vh"
module branch_prediction_unit_bench;
	logic clk = 0, rst = 1, ctrl_wr = 0, flush_pred = 0, lk_valid = 0, lk_link = 0;
	logic lk_onto_pred = 0, lk_bkpt_abort = 0, sb_valid = 0, sb_dyn_hit = 0, sb_cond = 0;
	logic sb_call = 0, sb_ret = 0, rs_valid, rs_taken, rs_call, rs_mispredict, rs_fold_fail;
	logic [1:0] exec_state = `BPU_ST_NATIVE;
	logic [3:0] lk_cond = 0, lk_cond_reg;
	logic [31:0] ctrl_wdata = 0, lk_addr = 0, sb_pc = 0, sb_next_pc = 0, sb_offset = 0;
	logic [31:0] rs_pc, rs_target, rs_ret_addr, lk_target_reg, lk_recover_reg;
	logic [31:0] sb_target_reg, sb_recover_reg, restart_pc_reg;
	logic pred_en_reg, lk_hit_reg, lk_taken_reg, lk_fold_reg, sb_redirect_reg;
	logic flush_fetch_reg, kill_next_reg;
	int error_cnt = 0, checks_done = 0, cyc = 0;
	localparam logic [31:0] PA = 32'h0000_1040, PB = 32'h0000_1240, TA = 32'h0000_0F00;
	localparam logic [31:0] PS = 32'h0000_2000, NG = 32'hFFFF_FFF0, FW = 32'h0000_0010;
	bpu_top uut (.*);
	bpu_pipe_model pipe (.*);
	always #12.5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			print_verdict;
		end
	end
	task automatic tick;
		@(posedge clk);
		#1;
	endtask
	task automatic chk(input string n, input logic [31:0] e, s);
		checks_done++;
		if (e !== s) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic ctrl(input logic en);
		tick;
		ctrl_wr = 1;
		ctrl_wdata = {20'h0_0000, en, 11'h000};
		tick;
		ctrl_wr = 0;
		chk("enable", en, pred_en_reg);
	endtask
	task automatic look(input logic [31:0] a, input logic [2:0] nf, input logic h, t,
		input logic [31:0] tg, rc);
		tick;
		lk_valid = 1;
		lk_addr = a;
		lk_cond = a[7:4];
		{lk_link, lk_onto_pred, lk_bkpt_abort} = nf;
		tick;
		lk_valid = 0;
		tick;
		chk("hit", h, lk_hit_reg);
		if (h) begin
			chk("taken", t, lk_taken_reg);
			chk("recover", rc, lk_recover_reg);
			chk("cond", a[7:4], lk_cond_reg);
		end
		if (h && t) begin
			chk("fold", nf == 0, lk_fold_reg);
			chk("target", tg, lk_target_reg);
		end
	endtask
	task automatic cand(input logic [31:0] off, input logic [3:0] k, input logic r1, r2,
		input logic [31:0] tg);
		tick;
		sb_valid = 1;
		sb_pc = PS;
		sb_next_pc = PS + 32'h0000_0004;
		sb_offset = off;
		{sb_cond, sb_call, sb_ret, sb_dyn_hit} = k;
		tick;
		sb_valid = 0;
		chk("early redirect", r1, sb_redirect_reg);
		if (r1) chk("return target", tg, sb_target_reg);
		if (r2) chk("static recover", sb_next_pc, sb_recover_reg);
		tick;
		if (!k[1]) chk("static redirect", r2, sb_redirect_reg);
		if (r2) chk("static target", tg, sb_target_reg);
	endtask
	task automatic recov(input logic [31:0] tg, ra, input logic tk, ff);
		pipe.resolve(PA, tg, ra, tk, 0, 1, ff);
		chk("flush", 1'b1, flush_fetch_reg);
		chk("restart", tk ? tg : ra, restart_pc_reg);
		chk("kill", ff, kill_next_reg);
	endtask
	task automatic print_verdict;
		$display("Comparisons %0d, mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk);
		#1 rst = 0;
		chk("enable at reset", 1'b0, pred_en_reg);
		pipe.resolve(PA, TA, PA, 1, 0, 0, 0);
		look(PA, 0, 0, 0, TA, TA);
		ctrl(1);
		pipe.resolve(PA, TA, PA, 1, 0, 0, 0);
		for (int i = 0; i < 4; i++) look(PA, 3'b100 >> (3 - i), 1, 1, TA, PA + 4);
		repeat (3) pipe.resolve(PA, TA, PA, 0, 0, 0, 0);
		look(PA, 0, 1, 0, TA, TA);
		repeat (4) pipe.resolve(PA, TA, PA, 1, 0, 0, 0);
		pipe.resolve(PA, TA, PA, 0, 0, 0, 0);
		look(PA, 0, 1, 1, TA, PA + 4);
		pipe.resolve(PB, TA, PB, 0, 0, 0, 0);
		tick;
		lk_valid = 1;
		lk_addr = PB;
		tick;
		lk_addr = PA;
		tick;
		lk_valid = 0;
		chk("back to back hit", 1'b1, lk_hit_reg);
		tick;
		chk("evicted miss", 1'b0, lk_hit_reg);
		tick;
		flush_pred = 1;
		tick;
		flush_pred = 0;
		look(PB, 0, 0, 0, TA, TA);
		cand(NG, 4'b1000, 0, 1, PS + NG);
		cand(FW, 4'b1000, 0, 0, 0);
		cand(FW, 4'b0100, 0, 1, PS + FW);
		cand(NG, 4'b1100, 0, 0, 0);
		cand(NG, 4'b1001, 0, 0, 0);
		exec_state = `BPU_ST_BYTECODE;
		cand(NG, 4'b1000, 0, 0, 0);
		exec_state = `BPU_ST_COMPACT;
		cand(NG, 4'b1000, 0, 1, PS + NG);
		for (int i = 1; i < 5; i++) pipe.resolve(PS, TA, PS + i, 1, 1, 0, 0);
		cand(0, 4'b1010, 0, 0, 0);
		for (int i = 4; i > 1; i--) cand(0, 4'b0010, 1, 0, PS + i);
		cand(0, 4'b0010, 0, 0, 0);
		recov(TA, PA + 4, 0, 1);
		recov(TA, PA + 4, 1, 0);
		ctrl(0);
		print_verdict;
	end
endmodule // branch_prediction_unit_bench
